// file: logic/pmon_calc_pkg.sv
// constants and decode functions shared by the power monitor calculation engine
package pmon_calc_pkg;

  // register offsets
  localparam logic [2:0] ADDR_SETUP       = 3'h0;
  localparam logic [2:0] ADDR_SHUNT       = 3'h1;
  localparam logic [2:0] ADDR_BUS         = 3'h2;
  localparam logic [2:0] ADDR_POWER       = 3'h3;
  localparam logic [2:0] ADDR_CURRENT     = 3'h4;
  localparam logic [2:0] ADDR_CALIBRATION = 3'h5;

  // measurement_setup field positions and value after reset
  localparam int          AVG_LSB      = 9;
  localparam int          BUS_CT_LSB   = 6;
  localparam int          SHUNT_CT_LSB = 3;
  localparam int          MODE_LSB     = 0;
  localparam logic [15:0] SETUP_RESET  = 16'h4127;
  localparam logic [15:0] CAL_RESET    = 16'h0000;

  // mode bits: bit0 shunt enable, bit1 bus enable, bit2 continuous
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT   = 1;
  localparam int MODE_CONT_BIT  = 2;

  // arithmetic scaling
  localparam int          CURRENT_SHIFT = 11;    // divide by 2048
  localparam int          POWER_DIVISOR = 20000; // 25 current steps per power step
  localparam int          CLOCK_MHZ     = 100;   // cycles per microsecond
  localparam logic [15:0] POWER_MAX     = 16'hffff;

  // conversion period in microseconds for each 3-bit code
  function automatic int unsigned conversion_period_us(input logic [2:0] code);
    case (code)
      3'h0:    conversion_period_us = 140;
      3'h1:    conversion_period_us = 204;
      3'h2:    conversion_period_us = 332;
      3'h3:    conversion_period_us = 588;
      3'h4:    conversion_period_us = 1100;
      3'h5:    conversion_period_us = 2116;
      3'h6:    conversion_period_us = 4156;
      default: conversion_period_us = 8244;
    endcase
  endfunction

  // averaging count is a power of two; return its log2
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0:    avg_shift = 4'h0;
      3'h1:    avg_shift = 4'h2;
      3'h2:    avg_shift = 4'h4;
      3'h3:    avg_shift = 4'h6;
      3'h4:    avg_shift = 4'h7;
      3'h5:    avg_shift = 4'h8;
      3'h6:    avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction

endpackage

// file: logic/conversion_timer.sv
// counts out one conversion period and pulses when it has elapsed
`timescale 1ns/1ps
module conversion_timer
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // control
  input  wire logic        i_start,
  input  wire logic        i_abort,
  input  wire logic [23:0] i_cycles,
  // status
  output logic             o_done
);

  logic [23:0] count;
  logic        busy;

  // down counter; abort wins so a restarted run never sees a stale done
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_abort)
    begin
      count  <= 24'h000000;
      busy   <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_start)
    begin
      count  <= i_cycles;
      busy   <= 1'b1;
      o_done <= 1'b0;
    end
    else if (busy && count <= 24'h000001)
    begin
      busy   <= 1'b0;
      o_done <= 1'b1;
    end
    else
    begin
      count  <= busy ? count - 24'h000001 : count;
      o_done <= 1'b0;
    end
  end

endmodule

// file: logic/power_monitor_calc_engine.sv
// measurement sequencing, averaging and current/power scaling engine
`timescale 1ns/1ps
module power_monitor_calc_engine
#(
  parameter int unsigned CYCLES_PER_US = pmon_calc_pkg::CLOCK_MHZ
)
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // register access port
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  input  wire logic [2:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  // converter side
  input  wire logic [15:0] i_shunt_sample,
  input  wire logic [15:0] i_bus_sample,
  output logic             o_shunt_select,
  output logic             o_bus_select,
  // results
  output logic [15:0]      o_shunt_voltage,
  output logic [15:0]      o_bus_voltage,
  output logic [15:0]      o_current,
  output logic [15:0]      o_power,
  output logic             o_conversion_ready
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SHUNT = 5'b00010,
    ST_BUS   = 5'b00100,
    ST_ACC   = 5'b01000,
    ST_LOAD  = 5'b10000
  } seq_state_e;

  seq_state_e  state;
  logic [15:0] measurement_setup;
  logic [15:0] calibration;
  logic        run_pending;
  logic        timer_start;
  logic        timer_done;
  logic [23:0] timer_cycles;
  logic [10:0] sample_count;
  logic [15:0] shunt_raw;
  logic [15:0] bus_raw;
  logic [31:0] acc_shunt;
  logic [31:0] acc_bus;
  logic [31:0] acc_current;
  logic [31:0] acc_power;

  logic        setup_write;
  logic [2:0]  mode;
  logic [2:0]  shunt_ct;
  logic [2:0]  bus_ct;
  logic [3:0]  shift;
  logic [10:0] last_sample;
  logic [23:0] shunt_cycles;
  logic [23:0] bus_cycles;
  logic [31:0] product;
  logic [15:0] sample_current;
  logic [15:0] current_mag;
  logic [31:0] power_full;
  logic [15:0] sample_power;

  localparam int MODE_SHUNT = pmon_calc_pkg::MODE_SHUNT_BIT;
  localparam int MODE_BUS   = pmon_calc_pkg::MODE_BUS_BIT;

  // field decode of the setup register
  assign setup_write = i_reg_write && (i_reg_addr == pmon_calc_pkg::ADDR_SETUP);
  assign mode        = measurement_setup[pmon_calc_pkg::MODE_LSB +: 3];
  assign shunt_ct    = measurement_setup[pmon_calc_pkg::SHUNT_CT_LSB +: 3];
  assign bus_ct      = measurement_setup[pmon_calc_pkg::BUS_CT_LSB +: 3];
  assign shift       = pmon_calc_pkg::avg_shift(
                         measurement_setup[pmon_calc_pkg::AVG_LSB +: 3]);
  assign last_sample = 11'((32'h1 << shift) - 32'h1);

  // each channel has its own period, scaled to cycles at the clock rate
  assign shunt_cycles = 24'(pmon_calc_pkg::conversion_period_us(shunt_ct)
                            * CYCLES_PER_US);
  assign bus_cycles   = 24'(pmon_calc_pkg::conversion_period_us(bus_ct)
                            * CYCLES_PER_US);

  // current from the signed shunt sample; zero until calibrated
  assign product        = 32'($signed(shunt_raw) * $signed({1'b0, calibration}));
  assign sample_current = (calibration == 16'h0000) ? 16'h0000
                        : 16'($signed(product) >>> pmon_calc_pkg::CURRENT_SHIFT);

  // power magnitude; divisor 20000 makes one power step 25 current steps
  assign current_mag  = sample_current[15] ? 16'(-sample_current) : sample_current;
  assign power_full   = (32'(current_mag) * 32'(bus_raw))
                        / 32'(pmon_calc_pkg::POWER_DIVISOR);
  assign sample_power = (calibration == 16'h0000) ? 16'h0000
                      : (power_full > 32'(pmon_calc_pkg::POWER_MAX)) ? pmon_calc_pkg::POWER_MAX
                      : power_full[15:0];

  // software-written setup and calibration
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      measurement_setup <= pmon_calc_pkg::SETUP_RESET;
      calibration       <= pmon_calc_pkg::CAL_RESET;
    end
    else if (i_reg_write)
    begin
      if (i_reg_addr == pmon_calc_pkg::ADDR_SETUP)
        measurement_setup <= i_reg_wdata;
      if (i_reg_addr == pmon_calc_pkg::ADDR_CALIBRATION)
        calibration <= i_reg_wdata;
    end
  end

  // sequencer: shunt period, bus period, accumulate, repeat, then load
  // a setup write abandons the run so no half-averaged result is published
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state        <= ST_IDLE;
      run_pending  <= 1'b1;
      timer_start  <= 1'b0;
      timer_cycles <= 24'h000000;
      sample_count <= 11'h000;
    end
    else if (setup_write)
    begin
      state        <= ST_IDLE;
      run_pending  <= i_reg_wdata[MODE_SHUNT] || i_reg_wdata[MODE_BUS];
      timer_start  <= 1'b0;
      sample_count <= 11'h000;
    end
    else
    begin
      timer_start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          sample_count <= 11'h000;
          if (run_pending && (mode[pmon_calc_pkg::MODE_SHUNT_BIT]
                              || mode[pmon_calc_pkg::MODE_BUS_BIT]))
          begin
            run_pending  <= 1'b0;
            timer_start  <= 1'b1;
            timer_cycles <= mode[pmon_calc_pkg::MODE_SHUNT_BIT] ? shunt_cycles : bus_cycles;
            state        <= mode[pmon_calc_pkg::MODE_SHUNT_BIT] ? ST_SHUNT : ST_BUS;
          end
        end
        ST_SHUNT:
        begin
          if (timer_done)
          begin
            if (mode[pmon_calc_pkg::MODE_BUS_BIT])
            begin
              timer_start  <= 1'b1;
              timer_cycles <= bus_cycles;
              state        <= ST_BUS;
            end
            else
              state <= ST_ACC;
          end
        end
        ST_BUS:
        begin
          if (timer_done)
            state <= ST_ACC;
        end
        ST_ACC:
        begin
          if (sample_count == last_sample)
            state <= ST_LOAD;
          else
          begin
            sample_count <= sample_count + 11'h001;
            timer_start  <= 1'b1;
            timer_cycles <= mode[pmon_calc_pkg::MODE_SHUNT_BIT] ? shunt_cycles : bus_cycles;
            state        <= mode[pmon_calc_pkg::MODE_SHUNT_BIT] ? ST_SHUNT : ST_BUS;
          end
        end
        ST_LOAD:
        begin
          run_pending <= mode[pmon_calc_pkg::MODE_CONT_BIT];  // continuous restarts at once
          state       <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  conversion_timer u_timer
  (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_start  (timer_start),
    .i_abort  (setup_write),
    .i_cycles (timer_cycles),
    .o_done   (timer_done)
  );

  // capture the converter word when its period ends
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      shunt_raw <= 16'h0000;
      bus_raw   <= 16'h0000;
    end
    else if (timer_done && state == ST_SHUNT)
      shunt_raw <= i_shunt_sample;
    else if (timer_done && state == ST_BUS)
      bus_raw <= {1'b0, i_bus_sample[14:0]};  // bus is never negative
  end

  // accumulate every sample of the run; cleared while idle
  always_ff @(posedge i_clock)
  begin
    if (i_srst || state == ST_IDLE)
    begin
      acc_shunt   <= 32'h00000000;
      acc_bus     <= 32'h00000000;
      acc_current <= 32'h00000000;
      acc_power   <= 32'h00000000;
    end
    else if (state == ST_ACC)
    begin
      acc_shunt   <= acc_shunt + 32'($signed(shunt_raw));
      acc_bus     <= acc_bus + 32'(bus_raw);
      acc_current <= acc_current + 32'($signed(sample_current));
      acc_power   <= acc_power + 32'(sample_power);
    end
  end

  // averages reach the result registers only at the end of the run
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_shunt_voltage <= 16'h0000;
      o_bus_voltage   <= 16'h0000;
      o_current       <= 16'h0000;
      o_power         <= 16'h0000;
    end
    else if (calibration == 16'h0000)
    begin
      o_current <= 16'h0000;
      o_power   <= 16'h0000;
      if (state == ST_LOAD)
      begin
        o_shunt_voltage <= 16'($signed(acc_shunt) >>> shift);
        o_bus_voltage   <= 16'(acc_bus >> shift);
      end
    end
    else if (state == ST_LOAD)
    begin
      o_shunt_voltage <= 16'($signed(acc_shunt) >>> shift);
      o_bus_voltage   <= 16'(acc_bus >> shift);
      o_current       <= 16'($signed(acc_current) >>> shift);
      o_power         <= 16'(acc_power >> shift);
    end
  end

  // ready flag: set at load, cleared by a setup write other than power-down
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_conversion_ready <= 1'b0;
    else if (state == ST_LOAD)
      o_conversion_ready <= 1'b1;
    else if (setup_write && (i_reg_wdata[MODE_SHUNT] || i_reg_wdata[MODE_BUS]))
      o_conversion_ready <= 1'b0;
  end

  // channel select tells the converter which input is being measured
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_shunt_select <= 1'b0;
      o_bus_select   <= 1'b0;
    end
    else
    begin
      o_shunt_select <= (state == ST_SHUNT);
      o_bus_select   <= (state == ST_BUS);
    end
  end

  // register readback, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_reg_rdata <= 16'h0000;
    else if (i_reg_read)
    begin
      case (i_reg_addr)
        pmon_calc_pkg::ADDR_SETUP:       o_reg_rdata <= measurement_setup;
        pmon_calc_pkg::ADDR_SHUNT:       o_reg_rdata <= o_shunt_voltage;
        pmon_calc_pkg::ADDR_BUS:         o_reg_rdata <= o_bus_voltage;
        pmon_calc_pkg::ADDR_POWER:       o_reg_rdata <= o_power;
        pmon_calc_pkg::ADDR_CURRENT:     o_reg_rdata <= o_current;
        pmon_calc_pkg::ADDR_CALIBRATION: o_reg_rdata <= calibration;
        default:                         o_reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// file: sim/power_monitor_calc_engine_assertions.sv
// port-level checker for the power monitor calculation engine
`timescale 1ns/1ps
module power_monitor_calc_engine_checker
#(
  parameter int unsigned CYCLES_PER_US = 100
)
(
  // clock, reset and register port
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_reg_write,
  input wire logic        i_reg_read,
  input wire logic [2:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  // converter selects and results
  input wire logic        o_shunt_select,
  input wire logic        o_bus_select,
  input wire logic [15:0] o_shunt_voltage,
  input wire logic [15:0] o_bus_voltage,
  input wire logic [15:0] o_current,
  input wire logic [15:0] o_power,
  input wire logic        o_conversion_ready
);
  localparam int unsigned SEL_MAX = 8244 * CYCLES_PER_US + 4;
  logic [15:0] setup_copy;
  logic [15:0] cal_copy;
  logic [23:0] sel_run;

  // shadows of the writable registers, updated on the same edge as the engine
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      setup_copy <= pmon_calc_pkg::SETUP_RESET;
      cal_copy   <= pmon_calc_pkg::CAL_RESET;
    end
    else if (i_reg_write && i_reg_addr == pmon_calc_pkg::ADDR_SETUP)
      setup_copy <= i_reg_wdata;
    else if (i_reg_write && i_reg_addr == pmon_calc_pkg::ADDR_CALIBRATION)
      cal_copy <= i_reg_wdata;
  end

  // length of the shunt select pulse; 24 bits cover the longest period
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !o_shunt_select)
      sel_run <= 24'h0;
    else
      sel_run <= sel_run + 24'h1;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);

  property p_cal_zero;
    (cal_copy == 16'h0) && ($past(cal_copy) == 16'h0) |-> (o_current == 16'h0) && (o_power == 16'h0);
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("result nonzero without calibration");
  property p_one_channel;
    !(o_shunt_select && o_bus_select);
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("both channels selected");
  property p_hold_results;
    $changed(o_shunt_voltage) || $changed(o_bus_voltage) |-> !$past(o_shunt_select) && !$past(o_bus_select);
  endproperty
  a_hold_results: assert property (p_hold_results) else $error("result moved mid run");
  property p_ready_with_update;
    $changed(o_bus_voltage) |-> o_conversion_ready;
  endproperty
  a_ready_with_update: assert property (p_ready_with_update) else $error("update without ready");
  property p_unmapped;
    i_reg_read && (i_reg_addr > 3'h5) |=> o_reg_rdata == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_readback;
    i_reg_read && !i_reg_write && (i_reg_addr == 3'h0 || i_reg_addr == 3'h5)
      |=> o_reg_rdata == (($past(i_reg_addr) == 3'h0) ? $past(setup_copy) : $past(cal_copy));
  endproperty
  a_readback: assert property (p_readback) else $error("register readback wrong");
  property p_ready_clear;
    // a live select means no load is under way, so the set cannot race the clear
    i_reg_write && i_reg_addr == 3'h0 && i_reg_wdata[1:0] != 2'h0
      && (o_shunt_select || o_bus_select) |=> !o_conversion_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready kept after setup write");
  property p_period_bound;
    sel_run <= SEL_MAX;
  endproperty
  a_period_bound: assert property (p_period_bound) else $error("shunt period too long");
endmodule

bind power_monitor_calc_engine power_monitor_calc_engine_checker #(.CYCLES_PER_US(CYCLES_PER_US))
  checker_i (.i_clock, .i_srst, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_shunt_select, .o_bus_select, .o_shunt_voltage, .o_bus_voltage,
  .o_current, .o_power, .o_conversion_ready);

// file: sim/shunt_bus_source.sv
// behavioural shunt and bus converter source facing the engine's selects
`timescale 1ns/1ps
module shunt_bus_source
(
  // selects from the engine
  input  wire logic        i_shunt_select,
  input  wire logic        i_bus_select,
  // levels set by the bench
  input  wire logic [15:0] i_shunt_level,
  input  wire logic [15:0] i_bus_level,
  // converter words to the engine
  output logic [15:0]      o_shunt_sample,
  output logic [15:0]      o_bus_sample
);
  // an unselected channel shows the inverse word so a stale capture shows up
  assign o_shunt_sample = i_shunt_select ? i_shunt_level : ~i_shunt_level;
  assign o_bus_sample   = i_bus_select ? i_bus_level : ~i_bus_level;
endmodule

// file: sim/tb_power_monitor_calc_engine.sv
// self-checking bench for the power monitor calculation engine
`timescale 1ns/1ps
module tb_power_monitor_calc_engine;
  localparam int unsigned CPU = 1;
  localparam int PERIOD_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  logic        i_clock;
  logic        i_srst;
  logic        i_reg_write;
  logic        i_reg_read;
  logic [2:0]  i_reg_addr;
  logic [15:0] i_reg_wdata;
  logic [15:0] o_reg_rdata;
  logic [15:0] i_shunt_sample;
  logic [15:0] i_bus_sample;
  logic        o_shunt_select;
  logic        o_bus_select;
  logic [15:0] o_shunt_voltage;
  logic [15:0] o_bus_voltage;
  logic [15:0] o_current;
  logic [15:0] o_power;
  logic        o_conversion_ready;
  logic [15:0] shunt_level;
  logic [15:0] bus_level;
  logic [15:0] rd;
  int          miscompares;
  int          total_checks;
  int          cycles;
  int          t;
  real         current_lsb;

  power_monitor_calc_engine #(.CYCLES_PER_US(CPU)) power_monitor_calc_engine_i
  (.i_clock, .i_srst, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
   .i_shunt_sample, .i_bus_sample, .o_shunt_select, .o_bus_select, .o_shunt_voltage,
   .o_bus_voltage, .o_current, .o_power, .o_conversion_ready);

  shunt_bus_source shunt_bus_source_i
  (.i_shunt_select(o_shunt_select), .i_bus_select(o_bus_select), .i_shunt_level(shunt_level),
   .i_bus_level(bus_level), .o_shunt_sample(i_shunt_sample), .o_bus_sample(i_bus_sample));

  // free-running 100 MHz clock
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // strobes are one cycle wide and change 1 ns after the edge
  task automatic reg_write(input logic [2:0] addr, input logic [15:0] data);
    @(posedge i_clock);
    #1;
    i_reg_write = 1'b1;
    i_reg_addr  = addr;
    i_reg_wdata = data;
    @(posedge i_clock);
    #1;
    i_reg_write = 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] addr, output logic [15:0] data);
    @(posedge i_clock);
    #1;
    i_reg_read = 1'b1;
    i_reg_addr = addr;
    @(posedge i_clock);
    #1;
    i_reg_read = 1'b0;
    data       = o_reg_rdata;
  endtask

  // bounded wait for the sticky ready flag
  task automatic wait_ready(output int n);
    n = 0;
    while (o_conversion_ready !== 1'b1)
    begin
      @(posedge i_clock);
      #1;
      n++;
      if (n > 20000)
      begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  // restart with a new setup and time the run; slack covers sequencing overhead
  task automatic run(input logic [15:0] setup, input int lo, input int hi);
    reg_write(pmon_calc_pkg::ADDR_SETUP, setup);
    @(posedge i_clock);
    #1;
    check({15'h0, o_conversion_ready}, 16'h0);
    wait_ready(cycles);
    check({15'h0, cycles >= lo && cycles <= hi}, 16'h1);
  endtask

  initial
  begin
    i_srst      = 1'b1;
    i_reg_write = 1'b0;
    i_reg_read  = 1'b0;
    i_reg_addr  = 3'h0;
    i_reg_wdata = 16'h0;
    shunt_level = 16'h1f40;
    bus_level   = 16'ha570; // top bit set on purpose, the engine must drop it
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    reg_read(pmon_calc_pkg::ADDR_SETUP, rd);
    check(rd, pmon_calc_pkg::SETUP_RESET);
    reg_read(pmon_calc_pkg::ADDR_CALIBRATION, rd);
    check(rd, 16'h0);
    reg_write(pmon_calc_pkg::ADDR_SHUNT, 16'h1234);
    reg_read(pmon_calc_pkg::ADDR_SHUNT, rd);
    check(rd, 16'h0);
    reg_read(3'h6, rd);
    check(rd, 16'h0);
    $display("test reset_state done");
    wait_ready(cycles);
    check(o_shunt_voltage, 16'h1f40);
    check(o_bus_voltage, 16'h2570);
    check(o_power, 16'h0);
    reg_read(pmon_calc_pkg::ADDR_CURRENT, rd);
    check(rd, 16'h0);
    $display("test uncalibrated done");
    current_lsb = 1.0e-3; // rounded up from 15 A over 2^15
    reg_write(pmon_calc_pkg::ADDR_CALIBRATION, 16'(int'(0.00512 / (current_lsb * 2.0e-3))));
    reg_read(pmon_calc_pkg::ADDR_CALIBRATION, rd);
    check(rd, 16'h0a00);
    // every shunt code against the mirrored bus code
    for (int s = 0; s < 8; s++)
    begin
      t = (PERIOD_US[s] + PERIOD_US[7 - s]) * CPU;
      run({4'h0, 3'h0, 3'(7 - s), 3'(s), 3'h7}, t - 2, t + 20);
      check(o_current, 16'h2710);
      check(o_power, 16'h12b8);
    end
    $display("test period_codes done");
    shunt_level = 16'he0c0;
    t = 2 * PERIOD_US[0] * CPU;
    run({4'h0, 3'h1, 3'h0, 3'h0, 3'h7}, 4 * t - 2, 4 * (t + 10));
    check(o_shunt_voltage, 16'he0c0);
    check(o_current, 16'hd8f0);
    check(o_power, 16'h12b8);
    $display("test averaged_negative done");
    // one triggered run, then the engine must stay idle; power-down keeps ready
    t = 2 * PERIOD_US[0] * CPU;
    run({4'h0, 3'h0, 3'h0, 3'h0, 3'h3}, t - 2, t + 20);
    check(o_current, 16'hd8f0);
    repeat (t) @(posedge i_clock);
    #1;
    check({14'h0, o_shunt_select, o_bus_select}, 16'h0);
    reg_write(pmon_calc_pkg::ADDR_SETUP, 16'h0000);
    @(posedge i_clock);
    #1;
    check({15'h0, o_conversion_ready}, 16'h1);
    $display("test triggered_and_off done");
    reg_write(pmon_calc_pkg::ADDR_CALIBRATION, 16'h0);
    repeat (2) @(posedge i_clock);
    #1;
    check(o_current, 16'h0);
    check(o_power, 16'h0);
    check(o_bus_voltage, 16'h2570);
    $display("test calibration_cleared done");
    i_srst = 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    check(o_shunt_voltage, 16'h0);
    reg_read(pmon_calc_pkg::ADDR_SETUP, rd);
    check(rd, pmon_calc_pkg::SETUP_RESET);
    $display("test second_reset done");
    report_and_stop();
  end
endmodule
